// ==== rtl/port_stats_pkg.sv ====
package port_stats_pkg;
  // Register byte offsets
  localparam logic [11:0] GLOBAL_CTRL_OFS  = 12'h000;
  localparam logic [11:0] IRQ_STATUS_OFS   = 12'h004;
  localparam logic [11:0] IRQ_MASK_OFS     = 12'h008;
  // Per-port page: 0x100 + port * 0x10, word 0 control/status, word 1 value
  localparam logic [3:0]  PORT_PAGE        = 4'h1;
  localparam logic [1:0]  PORT_CS_WORD     = 2'h0;
  localparam logic [1:0]  PORT_VAL_WORD    = 2'h1;
  // Control/status word fields
  localparam int          SEL_LSB          = 16;
  localparam int          SEL_MSB          = 23;
  localparam int          PART_BIT         = 24;
  localparam int          PEND_BIT         = 25;
  localparam int          OVF_BIT          = 31;
  localparam int          HI_MSB           = 3;
  // Global control word
  localparam int          GLOBAL_W         = 8;
  localparam int          FREEZE_BIT       = 6;
  localparam int          FLUSH_BIT        = 7;
  localparam logic [7:0]  GLOBAL_CTRL_RST  = 8'h00;
  // Counter index map
  localparam logic [7:0]  LOW_IDX_LIMIT    = 8'h20;
  localparam logic [5:0]  HIGH_IDX_PAGE    = 6'h20;
  localparam int          LOW_SLOTS        = 32;
  localparam int          NUM_SLOTS        = 36;
  localparam int          WIDE_SLOT_A      = 32;
  localparam int          WIDE_SLOT_B      = 33;
  localparam int          CNT_W            = 36;
  localparam logic [35:0] NARROW_MAX       = 36'h0_3FFF_FFFF;
  localparam logic [35:0] WIDE_MAX         = 36'hF_FFFF_FFFF;
  // AHB
  localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
  localparam logic        HRESP_OKAY       = 1'b0;
endpackage

// ==== rtl/port_stats_counter_access.sv ====
module port_stats_counter_access #(
  parameter int NUM_PORTS = 5
) (
  input  wire logic                                        sys_clk,
  input  wire logic                                        rst_n,
  input  wire logic                                        hsel,
  input  wire logic [31:0]                                 haddr,
  input  wire logic [1:0]                                  htrans,
  input  wire logic                                        hwrite,
  input  wire logic [2:0]                                  hsize,
  input  wire logic [31:0]                                 hwdata,
  input  wire logic                                        hready,
  output logic                                             hreadyout,
  output logic                                             hresp,
  output logic [31:0]                                      hrdata,
  input  wire logic [NUM_PORTS*port_stats_pkg::NUM_SLOTS-1:0] cntEvent,
  output logic                                             irq
);
  localparam int NS = port_stats_pkg::NUM_SLOTS;

  // Bus data-phase state
  logic                  dpValid;
  logic                  dpWrite;
  logic [11:0]           dpAddr;
  localparam int GLOBAL_W_T = port_stats_pkg::GLOBAL_W;
  logic [GLOBAL_W_T-1:0] globalCtrl;
  logic [2*NUM_PORTS-1:0] irqStatus;
  logic [2*NUM_PORTS-1:0] irqMask;

  // Per-port state
  logic [7:0]  sel       [NUM_PORTS];
  logic        part      [NUM_PORTS];
  logic        pend      [NUM_PORTS];
  logic [31:0] valueWord [NUM_PORTS];
  logic [3:0]  hiBits    [NUM_PORTS];
  logic        ovfCap    [NUM_PORTS];
  logic [35:0] cnt       [NUM_PORTS][NS];
  logic        ovf       [NUM_PORTS][NS];
  logic [35:0] selCnt    [NUM_PORTS];
  logic        selOvf    [NUM_PORTS];
  logic [31:0] csWord    [NUM_PORTS];
  logic [NUM_PORTS-1:0][NS-1:0] wrapVec;
  logic [NUM_PORTS-1:0] doneEvt;
  logic [NUM_PORTS-1:0] wrapEvt;

  // Address decode
  wire        addrAccept  = hsel & hready & (htrans == port_stats_pkg::HTRANS_NONSEQ);
  wire        rdAccept    = addrAccept & ~hwrite;
  wire        dpWr        = dpValid & dpWrite;
  wire        dpPortPage  = (dpAddr[11:8] == port_stats_pkg::PORT_PAGE);
  wire [3:0]  dpPort      = dpAddr[7:4];
  wire        dpCsWord    = dpPortPage & (dpAddr[3:2] == port_stats_pkg::PORT_CS_WORD);
  wire        globalWr    = dpWr & (dpAddr == port_stats_pkg::GLOBAL_CTRL_OFS);
  wire        maskWr      = dpWr & (dpAddr == port_stats_pkg::IRQ_MASK_OFS);
  wire [11:0] rdOfs       = haddr[11:0];
  wire [3:0]  rdPort      = haddr[7:4];
  wire        rdPortOk    = (haddr[11:8] == port_stats_pkg::PORT_PAGE) && (32'(rdPort) < NUM_PORTS);
  wire        statusRead  = rdAccept & (rdOfs == port_stats_pkg::IRQ_STATUS_OFS);
  wire        freezeCmd   = globalCtrl[port_stats_pkg::FREEZE_BIT];
  wire        flushCmd    = globalCtrl[port_stats_pkg::FLUSH_BIT];

  // Read selection
  wire [31:0] portRead =
    (haddr[3:2] == port_stats_pkg::PORT_CS_WORD)  ? csWord[rdPort[$clog2(NUM_PORTS)-1:0]] :
    (haddr[3:2] == port_stats_pkg::PORT_VAL_WORD) ? valueWord[rdPort[$clog2(NUM_PORTS)-1:0]] : 32'h0000_0000;
  wire [31:0] readMux =
    (rdOfs == port_stats_pkg::GLOBAL_CTRL_OFS) ? {24'h00_0000, globalCtrl} :
    (rdOfs == port_stats_pkg::IRQ_STATUS_OFS)  ? 32'(irqStatus) :
    (rdOfs == port_stats_pkg::IRQ_MASK_OFS)    ? 32'(irqMask) :
    rdPortOk                                   ? portRead : 32'h0000_0000;

  assign hreadyout = 1'b1;
  assign hresp     = port_stats_pkg::HRESP_OKAY;
  assign irq       = |(irqStatus & irqMask);

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      dpValid <= 1'b0;
      dpWrite <= 1'b0;
      dpAddr  <= 12'h000;
      hrdata  <= 32'h0000_0000;
    end
    else
    begin
      dpValid <= addrAccept;
      dpWrite <= hwrite;
      dpAddr  <= haddr[11:0];
      if (rdAccept)
        hrdata <= readMux;
    end
  end

  // Global control, mask and sticky status
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      globalCtrl <= port_stats_pkg::GLOBAL_CTRL_RST;
      irqMask    <= '0;
      irqStatus  <= '0;
    end
    else
    begin
      if (globalWr)
        globalCtrl <= hwdata[GLOBAL_W_T-1:0];
      if (maskWr)
        irqMask <= hwdata[2*NUM_PORTS-1:0];
      irqStatus <= (irqStatus & ~{2*NUM_PORTS{statusRead}}) | {wrapEvt, doneEvt};
    end
  end

  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_port
    wire       csWr     = dpWr & dpCsWord & (32'(dpPort) == p);
    wire       lowHit   = sel[p] < port_stats_pkg::LOW_IDX_LIMIT;
    wire       highHit  = (sel[p][7:2] == port_stats_pkg::HIGH_IDX_PAGE);
    wire       slotOk   = lowHit | highHit;
    wire [5:0] slot     = lowHit ? {1'b0, sel[p][4:0]} : (6'(port_stats_pkg::LOW_SLOTS) + {4'h0, sel[p][1:0]});
    wire       frz      = part[p] & freezeCmd;
    wire       flush    = part[p] & flushCmd;

    assign selCnt[p]  = slotOk ? cnt[p][slot] : 36'h0_0000_0000;
    assign selOvf[p]  = slotOk & ovf[p][slot];
    assign csWord[p]  = {ovfCap[p], 5'h00, pend[p], part[p], sel[p], 12'h000, hiBits[p]};
    assign doneEvt[p] = pend[p];
    assign wrapEvt[p] = |wrapVec[p];

    // Control/status register and capture
    always_ff @(posedge sys_clk)
    begin
      if (!rst_n)
      begin
        sel[p]       <= 8'h00;
        part[p]      <= 1'b0;
        pend[p]      <= 1'b0;
        valueWord[p] <= 32'h0000_0000;
        hiBits[p]    <= 4'h0;
        ovfCap[p]    <= 1'b0;
      end
      else if (pend[p])
      begin
        pend[p]      <= 1'b0;
        valueWord[p] <= selCnt[p][31:0];
        hiBits[p]    <= selCnt[p][35:32];
        ovfCap[p]    <= selOvf[p];
      end
      else if (csWr)
      begin
        sel[p]  <= hwdata[port_stats_pkg::SEL_MSB:port_stats_pkg::SEL_LSB];
        part[p] <= hwdata[port_stats_pkg::PART_BIT];
        pend[p] <= hwdata[port_stats_pkg::PEND_BIT];
      end
    end

    for (genvar s = 0; s < NS; s++)
    begin : g_slot
      localparam logic [35:0] MAXV = (s == port_stats_pkg::WIDE_SLOT_A || s == port_stats_pkg::WIDE_SLOT_B)
                                     ? port_stats_pkg::WIDE_MAX : port_stats_pkg::NARROW_MAX;
      wire inc   = cntEvent[p*NS+s] & ~frz;
      wire rdHit = pend[p] & slotOk & (32'(slot) == s);
      wire atMax = (cnt[p][s] == MAXV);
      assign wrapVec[p][s] = inc & atMax & ~rdHit & ~flush;

      always_ff @(posedge sys_clk)
      begin
        if (!rst_n)
        begin
          cnt[p][s] <= 36'h0_0000_0000;
          ovf[p][s] <= 1'b0;
        end
        else if (flush)
        begin
          cnt[p][s] <= 36'h0_0000_0000;
          ovf[p][s] <= 1'b0;
        end
        else if (rdHit)
        begin
          cnt[p][s] <= {35'h0_0000_0000, inc};
          ovf[p][s] <= 1'b0;
        end
        else if (inc)
        begin
          cnt[p][s] <= atMax ? 36'h0_0000_0000 : cnt[p][s] + 36'h0_0000_0001;
          ovf[p][s] <= ovf[p][s] | atMax;
        end
      end
    end
  end

  // Checks on port 0
  wire        csWr0   = dpWr & dpCsWord & (dpPort == 4'h0);
  wire        rdHit00 = pend[0] & (sel[0] == 8'h00);
  wire        flush0  = part[0] & flushCmd;
  wire        frz0    = part[0] & freezeCmd;

  sequence seqReadReq;
    csWr0 && hwdata[port_stats_pkg::PEND_BIT] && !pend[0];
  endsequence

  sequence seqCapture;
    pend[0] ##1 !pend[0];
  endsequence

  property pReadDone;
    @(posedge sys_clk) disable iff (!rst_n)
    seqReadReq |=> seqCapture;
  endproperty

  a_pending_clears: assert property (pReadDone)
    else $error("read pending did not drop one cycle after capture");

  a_value_capture: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pend[0] |=> valueWord[0] == $past(selCnt[0][31:0]) && hiBits[0] == $past(selCnt[0][35:32]))
    else $error("value word does not match captured counter");

  a_ovf_report: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pend[0] |=> ovfCap[0] == $past(selOvf[0]))
    else $error("overflow bit does not match selected counter");

  a_read_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rdHit00 && !flush0 |=> cnt[0][0] == {35'h0_0000_0000, $past(cntEvent[0] & ~frz0)})
    else $error("counter not cleared by read");

  a_ovf_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rdHit00 |=> !ovf[0][0])
    else $error("overflow flag survived a read");

  a_ovf_wrap: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cnt[0][0] == port_stats_pkg::NARROW_MAX && cntEvent[0] && !frz0 && !flush0 && !rdHit00
    |=> ovf[0][0] && cnt[0][0] == 36'h0_0000_0000)
    else $error("wrap did not set overflow");

  a_freeze_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    frz0 && !flush0 && !rdHit00 |=> $stable(cnt[0][0]))
    else $error("frozen counter changed");

  a_flush_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    flush0 |=> cnt[0][0] == 36'h0_0000_0000)
    else $error("flushed counter not zero");

  a_count_runs: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(frz0 || flush0) && cntEvent[0] && !rdHit00 && cnt[0][0] != port_stats_pkg::NARROW_MAX
    |=> cnt[0][0] == $past(cnt[0][0]) + 36'h0_0000_0001)
    else $error("running counter did not increment");

  a_global_sync: assert property (@(posedge sys_clk) disable iff (!rst_n)
    globalWr && part[0] && hwdata[port_stats_pkg::FREEZE_BIT] |=> frz0)
    else $error("freeze not applied to participating port");

  a_done_status: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pend[0] |=> irqStatus[0])
    else $error("read completion did not set status");

  a_status_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    statusRead && !pend[0] |=> !irqStatus[0])
    else $error("status read did not clear completion bit");

  a_wrap_status: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wrapVec[0][0] |=> irqStatus[NUM_PORTS])
    else $error("counter wrap did not set status");

  a_flush_ovf: assert property (@(posedge sys_clk) disable iff (!rst_n)
    flush0 |=> !ovf[0][0])
    else $error("flush left overflow flag set");

  a_release_runs: assert property (@(posedge sys_clk) disable iff (!rst_n)
    globalWr && hwdata[7:0] == 8'h00 |=> !frz0 && !flush0)
    else $error("release did not resume counting");

  a_flush_cmd: assert property (@(posedge sys_clk) disable iff (!rst_n)
    globalWr && part[0] && hwdata[port_stats_pkg::FLUSH_BIT] && hwdata[port_stats_pkg::FREEZE_BIT] |=> flush0 && frz0)
    else $error("flush not applied to participating port");

  a_sel_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pend[0] |=> $stable(sel[0]))
    else $error("counter index changed during capture");

  a_cs_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    csWr0 && !pend[0]
    |=> sel[0] == $past(hwdata[port_stats_pkg::SEL_MSB:port_stats_pkg::SEL_LSB])
        && pend[0] == $past(hwdata[port_stats_pkg::PEND_BIT]))
    else $error("control word write not taken");

  a_busy_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pend[0] |=> $stable(part[0]))
    else $error("participation changed during capture");
endmodule

// ==== dv/port_stats_counter_access_tb.sv ====
module port_stats_counter_access_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NP = 5;
  logic                sys_clk;
  logic                rst_n;
  logic                hsel;
  logic [31:0]         haddr;
  logic [1:0]          htrans;
  logic                hwrite;
  logic [2:0]          hsize;
  logic [31:0]         hwdata;
  logic                hreadyout;
  logic                hresp;
  logic [31:0]         hrdata;
  logic [NP*36-1:0]    cntEvent;
  logic                irq;
  int                  n_errors;
  int                  tests_run;
  int                  cycles;
  port_stats_counter_access #(.NUM_PORTS(NP)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cntEvent(cntEvent), .irq(irq));
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      results();
    end
  end
  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One single AHB-Lite transfer; wait on hready in both phases
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
    check("hresp", {35'h0, hresp}, 36'h0);
  endtask
  task automatic ev(input int p, input int s, input int n);
    repeat (n)
    begin
      cntEvent[p*36+s] <= 1'b1;
      @(posedge sys_clk);
      cntEvent <= '0;
      @(posedge sys_clk);
    end
  endtask
  function automatic logic [7:0] idxOf(input int s);
    return (s < 32) ? 8'(s) : 8'(8'h80 + s - 32);
  endfunction
  // Indirect counter read through control/status and value words
  task automatic rdcnt(input int p, input int s, input logic part, output logic [35:0] v);
    logic [31:0] cs;
    logic [31:0] r;
    logic [31:0] a;
    a = 32'h100 + 32'(p) * 32'h10;
    xfer(1'b1, a, {6'h00, 1'b1, part, idxOf(s), 16'h0000}, r);
    xfer(1'b0, a, 32'h0, cs);
    check("pending", {35'h0, cs[25]}, 36'h1);
    xfer(1'b0, a, 32'h0, cs);
    check("done", {35'h0, cs[25]}, 36'h0);
    check("select", {28'h0, cs[23:16]}, {28'h0, idxOf(s)});
    check("participate", {35'h0, cs[24]}, {35'h0, part});
    check("overflow", {35'h0, cs[31]}, 36'h0);
    xfer(1'b0, a + 32'h4, 32'h0, r);
    v = {cs[3:0], r};
  endtask
  initial
  begin
    logic [31:0] r;
    logic [35:0] v;
    int p;
    int s;
    int n;
    int m;
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    cntEvent = '0;
    void'($urandom(32'h5A46));
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    xfer(1'b0, 32'h000, 32'h0, r);
    check("global reset", 36'(r), 36'h0);
    xfer(1'b1, 32'h008, 32'h0000_03FF, r);
    for (int i = 0; i < 14; i++)
    begin
      p = $urandom_range(NP - 1);
      s = (i < 2) ? 32 + i : $urandom_range(35);
      n = $urandom_range(12, 1);
      ev(p, s, n);
      rdcnt(p, s, 1'b0, v);
      check("count", v, 36'(n));
      check("irq on", {35'h0, irq}, 36'h1);
      xfer(1'b0, 32'h004, 32'h0, r);
      check("status", 36'(r), 36'(1 << p));
      check("irq off", {35'h0, irq}, 36'h0);
      rdcnt(p, s, 1'b0, v);
      check("cleared", v, 36'h0);
      xfer(1'b0, 32'h004, 32'h0, r);
      check("status again", 36'(r), 36'(1 << p));
    end
    // Port 0 opts in, port 1 does not
    s = $urandom_range(35);
    n = $urandom_range(9, 2);
    m = $urandom_range(9, 2);
    rdcnt(0, s, 1'b1, v);
    rdcnt(1, s, 1'b0, v);
    xfer(1'b1, 32'h000, 32'h0000_0040, r);
    xfer(1'b0, 32'h000, 32'h0, r);
    check("global word", 36'(r), 36'h40);
    ev(0, s, m);
    ev(1, s, m);
    xfer(1'b1, 32'h000, 32'h0000_00C0, r);
    xfer(1'b1, 32'h000, 32'h0000_0000, r);
    ev(0, s, n);
    ev(1, s, n);
    xfer(1'b1, 32'h000, 32'h0000_0040, r);
    ev(0, s, m);
    ev(1, s, m);
    rdcnt(0, s, 1'b1, v);
    check("frozen", v, 36'(n));
    rdcnt(1, s, 1'b0, v);
    check("not joined", v, 36'(n + 2 * m));
    xfer(1'b1, 32'h000, 32'h0000_0000, r);
    ev(0, s, n);
    xfer(1'b1, 32'h000, 32'h0000_00C0, r);
    ev(0, s, m);
    xfer(1'b1, 32'h000, 32'h0000_0000, r);
    rdcnt(0, s, 1'b1, v);
    check("flushed", v, 36'h0);
    xfer(1'b0, 32'h00C, 32'h0, r);
    check("unmapped", 36'(r), 36'h0);
    xfer(1'b0, 32'h100 + NP * 32'h10, 32'h0, r);
    check("absent port", 36'(r), 36'h0);
    results();
  end
endmodule
